// *** rtl/mathpp_pkg.sv ***
package mathpp_pkg;

  // ----------------------------------------------------------------
  // Datapath format
  // ----------------------------------------------------------------
  // Readings and constants are signed fixed point
  localparam int DATA_W = 32;
  localparam int FRAC_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int COUNT_W = 16;
  localparam int FUNC_COUNT = 2;

  // base_ten_magnitude_mode(2) in Q16, used to turn log2 into base_ten_magnitude_mode
  localparam int LOG_CONST_FRAC = 16;
  localparam logic [15:0] BASE_TEN_MAGNITUDE_MODE_OF_2_Q16 = 16'h4d10;

  // ----------------------------------------------------------------
  // Unit label characters
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_FIRST_LETTER = 8'h41;
  localparam logic [7:0] UNIT_LAST_LETTER = 8'h5a;
  localparam logic [7:0] UNIT_OHM_CHAR = 8'h5b;
  localparam logic [7:0] UNIT_DEGREE_CHAR = 8'h5c;
  localparam logic [7:0] UNIT_PERCENT_CHAR = 8'h5d;
  localparam logic [7:0] UNIT_RESET_CHAR = 8'h41;

  // ----------------------------------------------------------------
  // Modes and selectors
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    scale_offset_mode,
    reciprocal_mode,
    base_ten_magnitude_mode
  } math_func_e;

  typedef enum logic {
    func_current,
    func_resistance
  } meas_func_e;

  typedef enum logic {
    raw_measurement_source,
    math_stage_output
  } null_feed_e;

endpackage : mathpp_pkg

// *** rtl/reading_math_postprocessor.sv ***
// ------------------------------------------------------------------
// Reading FIFO
// ------------------------------------------------------------------
module reading_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic space_ff;
  logic avail_ff;
  logic push;
  logic pop;

  // Flags are registered so both handshake outputs come from flops
  assign push = wr_valid & space_ff;
  assign pop = rd_ready & avail_ff;
  assign wr_ready = space_ff;
  assign rd_valid = avail_ff;
  assign rd_data = slots[rd_ptr_ff];

  // Occupancy
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CNT_W'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CNT_W'(1);
    end
  end

  // Storage needs no reset; only valid slots are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      slots[wr_ptr_ff] <= wr_data;
    end
  end

  // Pointers and flags
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      space_ff <= 1'b1;
      avail_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_SLOT) ? '0 : wr_ptr_ff + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_SLOT) ? '0 : rd_ptr_ff + PTR_W'(1);
      end
      count_ff <= nxt_count;
      space_ff <= (nxt_count != FULL_COUNT);
      avail_ff <= (nxt_count != '0);
    end
  end
endmodule : reading_fifo

// Operation
// - Enabled null outputs reading minus baseline
// - One baseline for all ranges; stays enabled
// - Acquire stores present input as baseline
// - Accept written baseline; panel entry enables null
// - Null input is raw or math output
// - Host enables null; disabled passes unchanged
// - Separate baselines for current and resistance
// - All null results since trigger, plus latest; the code keeps only their count and latest_null
// - Scale mode: scale times reading plus offset
// - Reciprocal mode: scale over reading plus offset
// - One scale/offset pair shared by both modes
// - Log mode: base_ten_magnitude_mode of reading magnitude
// - Exactly three math function choices
// - Scale and offset written by separate commands
// - One-character unit label, letters and symbols
// - Host enables math; annunciator shows it
// - All math results since trigger, plus latest; the code keeps only their count and latest_math
// - Stored readings carry the null result when null is on, else math
module reading_math_postprocessor
  import mathpp_pkg::*;
#(
  parameter int DATA_W_P = mathpp_pkg::DATA_W,
  parameter int FRAC_W_P = mathpp_pkg::FRAC_W,
  parameter int DEPTH_P = mathpp_pkg::FIFO_DEPTH,
  parameter int COUNT_W_P = mathpp_pkg::COUNT_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [DATA_W_P-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [DATA_W_P-1:0] out_stored,
  output logic signed [DATA_W_P-1:0] out_math,
  output logic signed [DATA_W_P-1:0] out_null,
  output logic out_invalid,
  input wire logic trigger,
  input wire mathpp_pkg::meas_func_e meas_func,
  input wire mathpp_pkg::null_feed_e null_feed,
  input wire logic null_state_wr,
  input wire logic null_state_val,
  input wire logic baseline_wr,
  input wire logic baseline_panel_wr,
  input wire logic signed [DATA_W_P-1:0] baseline_val,
  input wire logic acquire,
  input wire mathpp_pkg::math_func_e math_func,
  input wire logic math_enable,
  input wire logic scale_wr,
  input wire logic signed [DATA_W_P-1:0] scale_val,
  input wire logic offset_wr,
  input wire logic signed [DATA_W_P-1:0] offset_val,
  input wire logic unit_wr,
  input wire logic [7:0] unit_char,
  output logic null_enabled,
  output logic math_annunciator,
  output logic [7:0] result_unit_char,
  output logic signed [DATA_W_P-1:0] baseline_current,
  output logic signed [DATA_W_P-1:0] baseline_resistance,
  output logic signed [DATA_W_P-1:0] latest_null,
  output logic signed [DATA_W_P-1:0] latest_math,
  output logic [COUNT_W_P-1:0] results_since_trigger
);
  import mathpp_pkg::*;

  localparam int W2 = 2 * DATA_W_P;
  localparam logic [COUNT_W_P-1:0] COUNT_MAX = '1;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Legal unit label: A..Z or one of the three symbol codes
  function automatic logic unit_ok(input logic [7:0] c);
    unit_ok = ((c >= UNIT_FIRST_LETTER) && (c <= UNIT_LAST_LETTER)) ||
              (c == UNIT_OHM_CHAR) || (c == UNIT_DEGREE_CHAR) ||
              (c == UNIT_PERCENT_CHAR);
  endfunction : unit_ok

  // Position of the leading one
  function automatic int msb_index(input logic [DATA_W_P-1:0] v);
    msb_index = 0;
    for (int i = 0; i < DATA_W_P; i++) begin
      if (v[i]) begin
        msb_index = i;
      end
    end
  endfunction : msb_index

  // ----------------------------------------------------------------
  // Input buffering
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic [DATA_W_P-1:0] fifo_data;
  logic pop;
  logic signed [DATA_W_P-1:0] x;

  reading_fifo #(
    .WIDTH(DATA_W_P),
    .DEPTH(DEPTH_P)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data(in_data),
    .rd_valid(fifo_valid),
    .rd_ready(pop),
    .rd_data(fifo_data)
  );

  // Output slot stalls the FIFO, so back-pressure reaches in_ready
  assign pop = fifo_valid && (!out_valid || out_ready);
  assign x = signed'(fifo_data);

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic signed [DATA_W_P-1:0] scale_ff;
  logic signed [DATA_W_P-1:0] offset_ff;
  logic [7:0] unit_ff;
  logic math_on_ff;
  logic null_en_ff;
  logic signed [DATA_W_P-1:0] baseline_ff [FUNC_COUNT];
  logic signed [DATA_W_P-1:0] last_null_in_ff;

  // Shared constant pair; each has its own write strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scale_ff <= '0;
      offset_ff <= '0;
    end else begin
      if (scale_wr) begin
        scale_ff <= scale_val;
      end
      if (offset_wr) begin
        offset_ff <= offset_val;
      end
    end
  end

  // Unit label; illegal characters are ignored
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      unit_ff <= UNIT_RESET_CHAR;
    end else if (unit_wr && unit_ok(unit_char)) begin
      unit_ff <= unit_char;
    end
  end

  // Math enable and its annunciator
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      math_on_ff <= 1'b0;
    end else begin
      math_on_ff <= math_enable;
    end
  end

  // Null enable: a panel entry turns it on and wins over a host write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      null_en_ff <= 1'b0;
    end else if (baseline_panel_wr) begin
      null_en_ff <= 1'b1;
    end else if (null_state_wr) begin
      null_en_ff <= null_state_val;
    end
  end

  // ----------------------------------------------------------------
  // Math stage
  // ----------------------------------------------------------------
  logic signed [DATA_W_P-1:0] math_y;
  logic math_bad;
  logic signed [W2-1:0] prod;
  logic signed [W2-1:0] quot;
  logic signed [W2-1:0] divisor;
  logic signed [W2-1:0] log_prod;
  logic [DATA_W_P-1:0] mag;
  logic [DATA_W_P-1:0] norm;
  logic signed [DATA_W_P-1:0] log2_q;
  int lead;

  // Log uses a linear mantissa between powers of two
  always_comb begin
    mag = x[DATA_W_P-1] ? DATA_W_P'(-x) : DATA_W_P'(x);
    lead = msb_index(mag);
    norm = mag << (DATA_W_P - 1 - lead);
    log2_q = DATA_W_P'((lead - FRAC_W_P) * (2 ** FRAC_W_P)) +
             signed'(DATA_W_P'(norm[DATA_W_P-2 -: FRAC_W_P]));
    log_prod = W2'(log2_q) * signed'(W2'(BASE_TEN_MAGNITUDE_MODE_OF_2_Q16));
    prod = W2'(scale_ff) * W2'(x);
    divisor = (x == '0) ? W2'(1) : W2'(x);
    quot = (W2'(scale_ff) <<< FRAC_W_P) / divisor;
  end

  // Function select; unlisted code passes the reading through
  always_comb begin
    math_y = x;
    math_bad = 1'b0;
    if (math_enable) begin
      case (math_func)
        scale_offset_mode: begin
          math_y = DATA_W_P'(prod >>> FRAC_W_P) + offset_ff;
        end
        reciprocal_mode: begin
          if (x == '0) begin
            math_y = '0;
            math_bad = 1'b1;
          end else begin
            math_y = DATA_W_P'(quot) + offset_ff;
          end
        end
        base_ten_magnitude_mode: begin
          if (x == '0) begin
            math_y = '0;
            math_bad = 1'b1;
          end else begin
            math_y = DATA_W_P'(log_prod >>> LOG_CONST_FRAC);
          end
        end
        default: begin
          math_y = x;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baseline-null stage
  // ----------------------------------------------------------------
  logic signed [DATA_W_P-1:0] null_in;
  logic signed [DATA_W_P-1:0] base_sel;
  logic signed [DATA_W_P-1:0] null_y;
  logic signed [DATA_W_P-1:0] stored_y;
  logic signed [DATA_W_P-1:0] acq_val;
  logic null_bad;
  logic stored_bad;

  // No range input: one baseline serves every range
  always_comb begin
    null_in = (null_feed == math_stage_output) ? math_y : x;
    null_bad = (null_feed == math_stage_output) && math_bad;
    base_sel = baseline_ff[meas_func];
    null_y = null_en_ff ? null_in - base_sel : null_in;
    stored_y = null_en_ff ? null_y : math_y;
    stored_bad = null_en_ff ? null_bad : math_bad;
    acq_val = pop ? null_in : last_null_in_ff;
  end

  // Present null input, kept for an acquire between readings
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_null_in_ff <= '0;
    end else if (pop) begin
      last_null_in_ff <= null_in;
    end
  end

  // Baselines per function; an explicit write beats an acquire
  generate
    for (genvar f = 0; f < FUNC_COUNT; f++) begin : g_base
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          baseline_ff[f] <= '0;
        end else if (int'(meas_func) == f) begin
          if (baseline_wr || baseline_panel_wr) begin
            baseline_ff[f] <= baseline_val;
          end else if (acquire) begin
            baseline_ff[f] <= acq_val;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result slot and query state
  // ----------------------------------------------------------------
  logic [COUNT_W_P-1:0] count_ff;

  // Output slot holds while the consumer stalls
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_stored <= '0;
      out_math <= '0;
      out_null <= '0;
      out_invalid <= 1'b0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_stored <= stored_y;
      out_math <= math_y;
      out_null <= null_y;
      out_invalid <= stored_bad;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // Latest results for the single-value queries
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latest_null <= '0;
      latest_math <= '0;
    end else if (pop) begin
      latest_null <= null_y;
      latest_math <= math_y;
    end
  end

  // Results since trigger; a reading in the trigger cycle counts
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_ff <= '0;
    end else if (pop) begin
      if (trigger) begin
        count_ff <= COUNT_W_P'(1);
      end else if (count_ff != COUNT_MAX) begin
        count_ff <= count_ff + COUNT_W_P'(1);
      end
    end else if (trigger) begin
      count_ff <= '0;
    end
  end

  assign null_enabled = null_en_ff;
  assign math_annunciator = math_on_ff;
  assign result_unit_char = unit_ff;
  assign baseline_current = baseline_ff[func_current];
  assign baseline_resistance = baseline_ff[func_resistance];
  assign results_since_trigger = count_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_null_sub;
    @(posedge core_clk) disable iff (!resetn)
    pop && null_en_ff |=> out_null == $past(null_in) - $past(base_sel);
  endproperty
  a_null_sub: assert property (p_null_sub)
    else $error("null output is not input minus baseline");

  property p_null_pass;
    @(posedge core_clk) disable iff (!resetn)
    pop && !null_en_ff |=> out_null == $past(null_in);
  endproperty
  a_null_pass: assert property (p_null_pass)
    else $error("disabled null altered the reading");

  property p_acquire;
    @(posedge core_clk) disable iff (!resetn)
    acquire && !baseline_wr && !baseline_panel_wr |=>
      baseline_ff[$past(meas_func)] == $past(acq_val);
  endproperty
  a_acquire: assert property (p_acquire)
    else $error("acquire did not store the present input");

  property p_panel_enables;
    @(posedge core_clk) disable iff (!resetn)
    baseline_panel_wr |=> null_enabled && baseline_ff[$past(meas_func)]
      == $past(baseline_val);
  endproperty
  a_panel_enables: assert property (p_panel_enables)
    else $error("panel entry did not store and enable null");

  property p_other_base;
    @(posedge core_clk) disable iff (!resetn)
    meas_func == func_current |=> $stable(baseline_resistance);
  endproperty
  a_other_base: assert property (p_other_base)
    else $error("resistance baseline changed in current function");

  property p_zero_invalid;
    @(posedge core_clk) disable iff (!resetn)
    pop && math_enable && !null_en_ff && x == '0 &&
      (math_func == reciprocal_mode || math_func == base_ten_magnitude_mode)
      |=> out_invalid && out_math == '0;
  endproperty
  a_zero_invalid: assert property (p_zero_invalid)
    else $error("zero operand not flagged invalid");

  property p_annunciator;
    @(posedge core_clk) disable iff (!resetn)
    math_enable ##1 math_enable |-> math_annunciator;
  endproperty
  a_annunciator: assert property (p_annunciator)
    else $error("math annunciator off while math enabled");

  property p_count;
    @(posedge core_clk) disable iff (!resetn)
    trigger && !pop ##1 pop && !trigger |=> results_since_trigger == 1;
  endproperty
  a_count: assert property (p_count)
    else $error("count since trigger wrong");

  property p_hold;
    @(posedge core_clk) disable iff (!resetn)
    out_valid && !out_ready |=> out_valid && $stable(out_stored);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stored result dropped under stall");

  property p_unit;
    @(posedge core_clk) disable iff (!resetn)
    unit_wr && !unit_ok(unit_char) |=> $stable(result_unit_char);
  endproperty
  a_unit: assert property (p_unit)
    else $error("illegal unit character accepted");
endmodule : reading_math_postprocessor

// *** tb/result_sink.sv ***
// ----------------------------------------------------------------
// Result consumer
// ----------------------------------------------------------------
module result_sink (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hold,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [96:0] bundle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [96:0] q[$];
  logic [7:0] stall_ff;

  // Pseudo-random stalls, so the result slot is held now and then
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stall_ff <= 8'h5a;
    end else begin
      stall_ff <= {stall_ff[6:0], stall_ff[7] ^ stall_ff[5] ^ stall_ff[3]};
    end
  end

  assign out_ready = !hold && (stall_ff[1:0] != 2'b00);

  // Keep each accepted result whole, in arrival order
  always @(posedge core_clk) begin
    if (resetn && out_valid && out_ready) begin
      q.push_back(bundle);
    end
  end
endmodule : result_sink

// *** tb/reading_math_postprocessor_tb.sv ***
module reading_math_postprocessor_tb;
  import mathpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, resetn = 0, in_valid = 0, hold = 0, men = 0;
  logic nval = 0, nen = 0, out_valid, out_ready, in_ready, out_invalid;
  logic [7:0] stb = 8'h00, uch = 8'h41, unit_q;
  logic signed [31:0] in_data = 0, bval = 0, scv = 0, ofv = 0;
  logic signed [31:0] sc = 0, of = 0, bc = 0, br = 0;
  logic signed [31:0] o_st, o_m, o_n, bl_c, bl_r, lat_n, lat_m;
  logic [15:0] cnt;
  logic null_on, annun;
  logic [31:0] seed = 32'h82a0f44c;
  logic [96:0] last_e;
  math_func_e mf = scale_offset_mode;
  null_feed_e fd = raw_measurement_source;
  meas_func_e mfn = func_current;
  int err_total = 0, checked = 0, acc;

  always #50 core_clk = ~core_clk;

  reading_math_postprocessor i_reading_math_postprocessor (
    .core_clk(core_clk), .resetn(resetn), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_stored(o_st), .out_math(o_m),
    .out_null(o_n), .out_invalid(out_invalid), .trigger(stb[7]),
    .meas_func(mfn), .null_feed(fd), .null_state_wr(stb[0]),
    .null_state_val(nval), .baseline_wr(stb[1]),
    .baseline_panel_wr(stb[2]), .baseline_val(bval), .acquire(stb[3]),
    .math_func(mf), .math_enable(men), .scale_wr(stb[4]),
    .scale_val(scv), .offset_wr(stb[5]), .offset_val(ofv),
    .unit_wr(stb[6]), .unit_char(uch), .null_enabled(null_on),
    .math_annunciator(annun), .result_unit_char(unit_q),
    .baseline_current(bl_c), .baseline_resistance(bl_r),
    .latest_null(lat_n), .latest_math(lat_m),
    .results_since_trigger(cnt)
  );

  result_sink i_result_sink (
    .core_clk(core_clk), .resetn(resetn), .hold(hold),
    .out_valid(out_valid), .out_ready(out_ready),
    .bundle({out_invalid, o_st, o_m, o_n})
  );

  // ----------------------------------------------------------------
  // Expected results
  // ----------------------------------------------------------------
  // Log is only asked of +-1.0 and zero, where the estimate is exact
  function automatic logic [96:0] calc(logic signed [31:0] x);
    logic signed [63:0] p;
    logic signed [31:0] m, ni, nu, st;
    logic inv;
    inv = 1'b0;
    m = x;
    if (men) begin
      case (mf)
        scale_offset_mode: begin
          p = (64'(sc) * 64'(x)) >>> 16;
          m = p[31:0] + of;
        end
        reciprocal_mode: begin
          inv = (x == 0);
          p = inv ? 64'sh0 : (64'(sc) <<< 16) / 64'(x);
          m = inv ? 32'sh0 : p[31:0] + of;
        end
        base_ten_magnitude_mode: begin
          inv = (x == 0);
          m = 32'sh0;
        end
        default: m = x;
      endcase
    end
    ni = (fd == math_stage_output) ? m : x;
    nu = nen ? ni - ((mfn == func_resistance) ? br : bc) : ni;
    st = nen ? nu : m;
    if (nen && fd == raw_measurement_source) inv = 1'b0;
    return {inv, st, m, nu};
  endfunction : calc

  function automatic logic signed [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {{12{seed[19]}}, seed[19:0]};
  endfunction : rnd

  // ----------------------------------------------------------------
  // Drivers and checks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic pulse(int b);
    @(negedge core_clk);
    stb[b] = 1'b1;
    @(negedge core_clk);
    stb[b] = 1'b0;
  endtask : pulse

  // One reading in, its result compared whole at the consumer
  task automatic send_one(logic signed [31:0] x);
    logic [96:0] g;
    int n;
    last_e = calc(x);
    n = 0;
    @(negedge core_clk);
    in_valid = 1'b1;
    in_data = x;
    while (in_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    in_valid = 1'b0;
    while (i_result_sink.q.size() == 0 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    g = (n < 60) ? i_result_sink.q.pop_front() : ~last_e;
    chk("out_invalid", 32'(last_e[96]), 32'(g[96]));
    chk("out_stored", last_e[95:64], g[95:64]);
    chk("out_math", last_e[63:32], g[63:32]);
    chk("out_null", last_e[31:0], g[31:0]);
  endtask : send_one

  task automatic test_done();
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #4000000;
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    chk("unit_reset", 32'h41, 32'(unit_q));
    chk("in_ready_reset", 32'h1, 32'(in_ready));
    // Pass-through, then count and latest since trigger
    pulse(7);
    chk("count_trig", 32'h0, 32'(cnt));
    for (int i = 0; i < 4; i++) send_one(rnd());
    chk("count", 32'h4, 32'(cnt));
    chk("latest_math", last_e[63:32], lat_m);
    chk("latest_null", last_e[31:0], lat_n);
    // A reading popped in the trigger cycle counts as the first
    @(negedge core_clk);
    in_valid = 1'b1;
    in_data = 32'sh0;
    @(negedge core_clk);
    in_valid = 1'b0;
    stb[7] = 1'b1;
    @(negedge core_clk);
    stb[7] = 1'b0;
    chk("count_pop_trig", 32'h1, 32'(cnt));
    while (i_result_sink.q.size() == 0) @(negedge core_clk);
    last_e = i_result_sink.q.pop_front();
    chk("out_stored_trig", 32'h0, last_e[95:64]);
    // Scale-offset with random readings
    scv = 32'sh0002_0000;
    sc = scv;
    pulse(4);
    ofv = 32'sh0000_8000;
    of = ofv;
    pulse(5);
    men = 1'b1;
    @(negedge core_clk);
    chk("annunciator_on", 32'h1, 32'(annun));
    for (int i = 0; i < 6; i++) send_one(rnd());
    // Reciprocal shares the offset; only scale is rewritten
    mf = reciprocal_mode;
    scv = 32'sh0004_0000;
    sc = scv;
    pulse(4);
    send_one(32'sh0002_0000);
    send_one(32'shffff_0000);
    send_one(32'sh0);
    // Every selector code, zero and both signs
    for (int c = 0; c < 4; c++) begin
      mf = math_func_e'(c);
      send_one(32'sh0001_0000);
      send_one(32'shffff_0000);
      send_one(32'sh0);
    end
    // Separate baselines per function, fed raw or from math
    mf = scale_offset_mode;
    bval = 32'sh0003_0000;
    bc = bval;
    pulse(1);
    mfn = func_resistance;
    bval = 32'shfffe_8000;
    br = bval;
    pulse(1);
    chk("baseline_cur", bc, bl_c);
    chk("baseline_res", br, bl_r);
    nval = 1'b1;
    nen = 1'b1;
    pulse(0);
    send_one(rnd());
    fd = math_stage_output;
    send_one(rnd());
    mfn = func_current;
    send_one(rnd());
    mf = reciprocal_mode;
    send_one(32'sh0);
    mf = scale_offset_mode;
    nval = 1'b0;
    nen = 1'b0;
    pulse(0);
    send_one(rnd());
    // Acquire takes the last null input; panel entry enables null
    fd = raw_measurement_source;
    send_one(32'sh0005_4000);
    pulse(3);
    bc = 32'sh0005_4000;
    chk("acquire", bc, bl_c);
    bval = 32'sh0000_c000;
    bc = bval;
    pulse(2);
    nen = 1'b1;
    chk("panel_enable", 32'h1, 32'(null_on));
    send_one(rnd());
    // Unit label: letters and symbols kept, others ignored
    uch = UNIT_LAST_LETTER;
    pulse(6);
    chk("unit_z", 32'h5a, 32'(unit_q));
    uch = UNIT_OHM_CHAR;
    pulse(6);
    chk("unit_sym", 32'h5b, 32'(unit_q));
    uch = 8'h30;
    pulse(6);
    chk("unit_bad", 32'h5b, 32'(unit_q));
    // Fill the FIFO against a stalled consumer, then drain in order
    men = 1'b0;
    nval = 1'b0;
    nen = 1'b0;
    pulse(0);
    chk("annunciator_off", 32'h0, 32'(annun));
    hold = 1'b1;
    acc = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      in_valid = 1'b1;
      in_data = 32'(acc);
      if (in_ready === 1'b1) acc++;
    end
    @(negedge core_clk);
    in_valid = 1'b0;
    chk("full_refuses", 32'h0, 32'(in_ready));
    chk("fill_depth", 32'(FIFO_DEPTH + 1), 32'(acc)); // FIFO plus slot
    hold = 1'b0;
    for (int i = 0; i < 400 && i_result_sink.q.size() < acc; i++) begin
      @(negedge core_clk);
    end
    chk("drain_count", 32'(acc), 32'(i_result_sink.q.size()));
    for (int i = 0; i < acc && i_result_sink.q.size() > 0; i++) begin
      last_e = i_result_sink.q.pop_front();
      chk("drain_order", 32'(i), last_e[95:64]);
    end
    test_done();
  end
endmodule : reading_math_postprocessor_tb
